// ---- common/gatekeeper_params.svh ----
// Purpose: constants of the drive command gatekeeper
// Assumes: included by its bare name
// Notes: error codes are the 16-bit numbers the drive reports
`ifndef GATEKEEPER_PARAMS_SVH
`define GATEKEEPER_PARAMS_SVH
`define ERR_NONE 16'h0000
`define ERR_QUICKSTOP 16'ha301
`define ERR_USER_STOP 16'ha306
`define ERR_INT_STOP 16'ha307
`define ERR_FAULT 16'ha308
`define ERR_NOT_OPEN 16'ha309
`define ERR_NO_POWER 16'ha310
`define ERR_OVERRUN 16'ha313
`define ERR_NO_REF 16'ha314
`define ERR_HOMING 16'ha315
`define ERR_NOT_STILL 16'ha317
`define ERR_MODE_ACT 16'ha318
`define ERR_TUNE_RANGE 16'ha319
`define ERR_AMPLITUDE 16'ha31a
`define TUNE_RANGE_CLASS 2'h1
`define TUNE_RANGE_BIT 5'h02
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_IRQ 4'h2
`define REG_MASK 4'h3
`define REG_CMD 4'h4
`define REG_REPLY 4'h5
`define REG_LIMIT 4'h6
`define IRQ_REJECT 0
`define IRQ_FAULT 1
`define IRQ_OVERRUN 2
`define IRQ_TUNE 3
`define IRQ_W 4
`endif

// ---- common/gatekeeper_pkg.sv ----
// Purpose: types of the drive command gatekeeper
// Assumes: nothing
// Notes: command flags say which checks a command needs
package gatekeeper_pkg;
  typedef enum logic [2:0] {st_disabled, st_open, st_quickstop, st_fault} drive_e;
  typedef struct packed {
    logic activate;
    logic need_open;
    logic need_power;
    logic need_ref;
    logic absolute;
    logic homing_ok;
    logic need_still;
    logic fault_reset;
    logic halt;
    logic tune;
    logic [7:0] amplitude;
    logic [7:0] offset;
  } cmd_s;
  typedef struct packed {
    logic err_valid;
    logic [15:0] code;
    logic [1:0] err_class;
    logic [4:0] err_bit;
  } reply_s;
endpackage : gatekeeper_pkg

// ---- rtl/drive_command_gatekeeper.sv ----
// Purpose: accepts or refuses drive commands against the drive state
// Assumes: one 250 MHz clock, Avalon-MM slave with waitrequest
// Notes on behaviour
// R1 - quick stop from user software stop blocks new mode activation
// R2 - that refusal reports the user-stop error number
// R3 - a refused activation is answered with its error code
// R4 - homing or jog internal stop blocks activation, reports internal-stop code
// R5 - fault reset from master clears software stop break condition
// R6 - class two or higher error enters fault; refusals report fault code
// R7 - class one error brings quick stop instead of fault
// R8 - commands needing operation enable refused in other states
// R9 - power stage commands refused unless operation enabled or quick stop
// R10 - position overrun clears reference valid, reports overrun, blocks absolute
// R11 - reference commands refused while reference valid is zero
// R12 - commands not allowed during homing refused with homing code
// R13 - standstill-only commands refused while moving
// R14 - motion finished flag reads one at standstill outside a homing run
// R15 - activation while motion unfinished refused with mode-active code
// R16 - hold-stop command terminates the current mode
// R17 - tuning out of range raises class one bit two range error
// R18 - tuning amplitude plus offset above limit refused
// R19 - commands passing every check execute without error
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
`include "gatekeeper_params.svh"
module drive_command_gatekeeper (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_irq,
  input wire logic i_class_err,
  input wire logic i_class_two,
  input wire logic i_pos_overrun,
  input wire logic i_tune_out_range,
  input wire logic i_standstill,
  input wire logic i_homing_done,
  output gatekeeper_pkg::reply_s o_reply,
  output logic o_reply_valid,
  output logic o_mode_run
);
  import gatekeeper_pkg::*;

  // ==========================================================
  // state
  // all state but the output registers in one struct, the pin synchronisers included
  typedef struct packed {
    drive_e drive;
    logic user_stop;
    logic int_stop;
    logic ref_ok;
    logic homing;
    logic jog;
    logic tuning;
    logic mode_run;
    logic [15:0] limit;
    logic [`IRQ_W-1:0] irq;
    logic [`IRQ_W-1:0] mask;
    reply_s reply;
    logic reply_valid;
    logic [31:0] rdata;
    logic ack;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_c;
    logic [1:0] sync_d;
    logic [1:0] sync_e;
    logic [1:0] sync_f;
  } state_s;

  state_s s_q;
  state_s s_d;

  cmd_s cmd;
  logic access;
  logic err_c1;
  logic err_c2;
  logic overrun;
  logic tune_oor;
  logic still;
  logic home_end;
  logic [16:0] amp_sum;
  logic [`IRQ_W-1:0] ev;

  // ==========================================================
  // elaboration checks
  // the command word is taken from the low bits of one bus word
  if ($bits(cmd_s) > 32)
  begin : g_cmd_fits
    $error("command word does not fit the bus word");
  end
  // one sticky status bit for each event source
  if (`IRQ_W <= `IRQ_TUNE)
  begin : g_irq_fits
    $error("interrupt register narrower than its event sources");
  end

  function automatic reply_s make_reply(input logic [15:0] code);
    reply_s r;
    r.err_valid = (code != `ERR_NONE);
    r.code = code;
    r.err_class = 2'h0;
    r.err_bit = 5'h00;
    return r;
  endfunction : make_reply

  // one wait state: a request is answered on the edge after it is seen
  assign access = (i_read | i_write) & ~s_q.ack;
  assign cmd = cmd_s'(i_writedata[25:0]) ;
  // second stage of each synchroniser only
  assign err_c1 = s_q.sync_a[1];
  assign err_c2 = s_q.sync_b[1];
  assign overrun = s_q.sync_c[1];
  assign tune_oor = s_q.sync_d[1];
  assign still = s_q.sync_e[1];
  assign home_end = s_q.sync_f[1];
  // wide enough that amplitude plus offset never wraps below the limit
  assign amp_sum = {9'h000, cmd.amplitude} + {9'h000, cmd.offset};

  // ==========================================================
  // next state
  always_comb
  begin
    logic [15:0] code;
    logic [15:0] wmask;
    // every field but ack, reply_valid, rdata and the synchronisers holds by default; the blocks below only override
    code = `ERR_NONE;
    wmask = 16'h0000;
    s_d = s_q;
    ev = '0;
    s_d.sync_a = {s_q.sync_a[0], i_class_err};
    s_d.sync_b = {s_q.sync_b[0], i_class_two};
    s_d.sync_c = {s_q.sync_c[0], i_pos_overrun};
    s_d.sync_d = {s_q.sync_d[0], i_tune_out_range};
    s_d.sync_e = {s_q.sync_e[0], i_standstill};
    s_d.sync_f = {s_q.sync_f[0], i_homing_done};
    // ack keeps a held request from being served twice
    s_d.ack = access;
    s_d.reply_valid = 1'b0;

    // a finished homing run defines the reference point
    if (home_end && s_q.homing)
    begin
      s_d.homing = 1'b0;
      s_d.ref_ok = 1'b1;
    end

    // R14 motion finished
    if (still && !s_q.homing)
    begin
      s_d.mode_run = 1'b0;
      s_d.tuning = 1'b0;
    end

    // R6 fault entry
    if (err_c2)
    begin
      s_d.drive = st_fault;
      s_d.mode_run = 1'b0;
      ev[`IRQ_FAULT] = 1'b1;
    end
    // R7 class one quick stop
    else if (err_c1 && s_q.drive == st_open)
      s_d.drive = st_quickstop;

    // R4 internal stop in homing or jog
    if (overrun && (s_q.homing || s_q.jog) && s_q.drive == st_open)
    begin
      s_d.int_stop = 1'b1;
      s_d.drive = st_quickstop;
    end

    // R10 reference lost
    if (overrun)
    begin
      s_d.ref_ok = 1'b0;
      ev[`IRQ_OVERRUN] = 1'b1;
    end

    // R17 tuning range error
    if (tune_oor && s_q.tuning && s_q.drive == st_open)
    begin
      s_d.reply = make_reply(`ERR_TUNE_RANGE);
      s_d.reply.err_class = `TUNE_RANGE_CLASS;
      s_d.reply.err_bit = `TUNE_RANGE_BIT;
      s_d.reply_valid = 1'b1;
      s_d.drive = st_quickstop;
      s_d.tuning = 1'b0;
      ev[`IRQ_TUNE] = 1'b1;
    end

    // read data is registered and stands on the answering edge only
    s_d.rdata = 32'h0000_0000;
    if (access && i_read)
    begin
      if (i_address == `REG_CTRL)
        s_d.rdata = {16'h0000, s_q.limit};
      else if (i_address == `REG_STATUS)
        s_d.rdata = {24'h0, s_q.ref_ok, s_q.homing, ~s_q.mode_run, s_q.int_stop, s_q.user_stop, 3'(s_q.drive)};
      else if (i_address == `REG_IRQ)
        s_d.rdata = {28'h0, s_q.irq};
      else if (i_address == `REG_MASK)
        s_d.rdata = {28'h0, s_q.mask};
      else if (i_address == `REG_REPLY)
        s_d.rdata = {8'h00, s_q.reply};
      else if (i_address == `REG_LIMIT)
        s_d.rdata = {16'h0000, s_q.limit};
    end

    if (access && i_write)
    begin
      if (i_address == `REG_CTRL)
      begin
        // ctrl bits: software stop, enable, disable; the lowest set bit that the current drive state allows wins
        // user software stop request
        if (i_writedata[0] && s_q.drive == st_open)
        begin
          s_d.user_stop = 1'b1;
          s_d.drive = st_quickstop;
        end
        else if (i_writedata[1] && s_q.drive == st_disabled)
          s_d.drive = st_open;
        else if (i_writedata[2] && s_q.drive == st_open)
          s_d.drive = st_disabled;
      end
      // status bits are cleared by writing ones
      else if (i_address == `REG_IRQ)
        wmask[`IRQ_W-1:0] = i_writedata[`IRQ_W-1:0];
      else if (i_address == `REG_MASK)
        s_d.mask = i_writedata[`IRQ_W-1:0];
      else if (i_address == `REG_LIMIT)
        s_d.limit = i_writedata[15:0];
      else if (i_address == `REG_CMD)
      begin
        // R5 fault reset
        if (cmd.fault_reset)
        begin
          s_d.user_stop = 1'b0;
          s_d.int_stop = 1'b0;
          if (s_q.drive == st_fault || s_q.drive == st_quickstop)
            s_d.drive = st_open;
        end

        // R16 hold stop
        else if (cmd.halt)
        begin
          s_d.mode_run = 1'b0;
          s_d.homing = 1'b0;
          s_d.jog = 1'b0;
          s_d.tuning = 1'b0;
        end

        // R6 fault refusal
        else if (s_q.drive == st_fault)
          code = `ERR_FAULT;

        // R1 R2 user stop refusal
        else if (cmd.activate && s_q.user_stop)
          code = `ERR_USER_STOP;

        // R4 internal stop refusal
        else if (cmd.activate && s_q.int_stop)
          code = `ERR_INT_STOP;

        // R7 quick stop refusal
        else if (cmd.activate && s_q.drive == st_quickstop)
          code = `ERR_QUICKSTOP;

        // R9 power stage
        else if (cmd.need_power && s_q.drive != st_open && s_q.drive != st_quickstop)
          code = `ERR_NO_POWER;

        // R8 operation enable
        else if ((cmd.need_open || cmd.activate) && s_q.drive != st_open)
          code = `ERR_NOT_OPEN;

        // R12 homing active
        else if (s_q.homing && !cmd.homing_ok)
          code = `ERR_HOMING;

        // R10 absolute blocked
        else if (cmd.absolute && !s_q.ref_ok)
          code = `ERR_OVERRUN;

        // R11 no reference
        else if (cmd.need_ref && !s_q.ref_ok)
          code = `ERR_NO_REF;

        // R13 standstill needed
        else if (cmd.need_still && !still)
          code = `ERR_NOT_STILL;

        // R15 mode still active
        else if (cmd.activate && s_q.mode_run)
          code = `ERR_MODE_ACT;

        // R18 amplitude check
        else if (cmd.tune && amp_sum > {1'b0, s_q.limit})
          code = `ERR_AMPLITUDE;

        // R19 accepted
        else if (cmd.activate)
        begin
          s_d.mode_run = 1'b1;
          s_d.homing = cmd.homing_ok & ~cmd.need_ref;
          s_d.jog = cmd.homing_ok & cmd.need_ref;
          s_d.tuning = cmd.tune;
        end

        // R3 reply to same command
        s_d.reply = make_reply(code);
        s_d.reply_valid = 1'b1;
        ev[`IRQ_REJECT] = (code != `ERR_NONE);
      end
    end

    // set wins over clear
    s_d.irq = (s_q.irq & ~wmask[`IRQ_W-1:0]) | ev;
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.drive <= st_disabled;
      // limit resets wide open so no tuning setting is refused before software sets one
      s_q.limit <= 16'hffff;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  // loaded from the next state so each leaves a flip-flop in step with the state
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_readdata <= 32'h0000_0000;
      o_waitrequest <= 1'b1;
      o_irq <= 1'b0;
      o_reply <= '0;
      o_reply_valid <= 1'b0;
      o_mode_run <= 1'b0;
    end
    else
    begin
      o_readdata <= s_d.rdata;
      o_waitrequest <= ~access;
      // level interrupt from the next status and mask
      o_irq <= |(s_d.irq & s_d.mask);
      o_reply <= s_d.reply;
      o_reply_valid <= s_d.reply_valid;
      o_mode_run <= s_d.mode_run;
    end
  end
endmodule : drive_command_gatekeeper

// ---- verification/drive_command_gatekeeper_tb_top.sv ----
// Purpose: self-checking bench of the drive command gatekeeper
// Assumes: 250 MHz clock, registers on Avalon-MM
// Notes: a model of the drive state predicts each reply
`timescale 1ns/1ns
`include "gatekeeper_params.svh"
module drive_command_gatekeeper_tb_top;
  import gatekeeper_pkg::*;
  logic clock, rstn, class_err, class_two, overrun, tune_out, still, homed;
  logic [3:0] address;
  logic read, write, waitreq, irq, reply_valid, mode_run;
  logic [31:0] writedata, readdata, r, w;
  reply_s reply;
  logic [2:0] drv;
  logic usr, mode, ovr, hom, ist;
  logic [15:0] lim;
  integer seed = 32'ha720;
  int fails = 0;
  int checks = 0;
  drive_command_gatekeeper dut_u (.i_clock(clock), .i_rstn(rstn), .i_address(address), .i_read(read),
    .i_write(write), .i_writedata(writedata), .o_readdata(readdata), .o_waitrequest(waitreq), .o_irq(irq),
    .i_class_err(class_err), .i_class_two(class_two), .i_pos_overrun(overrun), .i_tune_out_range(tune_out),
    .i_standstill(still), .i_homing_done(homed), .o_reply(reply), .o_reply_valid(reply_valid),
    .o_mode_run(mode_run));
  gatekeeper_bus_master bm_u (.i_clock(clock), .i_waitrequest(waitreq), .i_readdata(readdata),
    .o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================
  // checking and bus tasks
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bm_u.access(1'b1, a, d, x);
  endtask : wr
  task automatic state(input logic [2:0] e);
    bm_u.access(1'b0, `REG_STATUS, 32'h0, r);
    check("drive state", {29'h0, r[2:0]}, {29'h0, e});
  endtask : state
  // priority of the state checks, fault first
  function automatic logic [15:0] expect_code(input logic [31:0] c);
    if (c[18] || c[17]) return `ERR_NONE;
    if (drv == 3'd3) return `ERR_FAULT;
    if (c[25] && drv == 3'd2) return usr ? `ERR_USER_STOP : (ist ? `ERR_INT_STOP : `ERR_QUICKSTOP);
    if (c[23] && drv != 3'd1 && drv != 3'd2) return `ERR_NO_POWER;
    if ((c[24] || c[25]) && drv != 3'd1) return `ERR_NOT_OPEN;
    if (hom && !c[20]) return `ERR_HOMING;
    if (c[21] && ovr) return `ERR_OVERRUN;
    if (c[22] && ovr) return `ERR_NO_REF;
    if (c[19] && !still) return `ERR_NOT_STILL;
    if (c[25] && mode) return `ERR_MODE_ACT;
    if (c[16] && 17'(c[15:8]) + 17'(c[7:0]) > 17'(lim)) return `ERR_AMPLITUDE;
    return `ERR_NONE;
  endfunction : expect_code
  task automatic cmd(input logic [31:0] c);
    logic [15:0] e;
    e = expect_code(c);
    if (e == `ERR_NONE && c[25])
    begin
      mode = 1'b1;
      hom = c[20] & ~c[22];
    end
    if (c[17])
    begin
      mode = 1'b0;
      hom = 1'b0;
    end
    wr(`REG_CMD, c);
    check("reply code", {16'h0, reply.code}, {16'h0, e});
    check("reply flag", {31'h0, reply.err_valid}, {31'h0, e != `ERR_NONE});
    check("mode run", {31'h0, mode_run}, {31'h0, mode});
  endtask : cmd
  task automatic recover();
    cmd(32'h0004_0000);
    wr(`REG_CTRL, 32'h2);
    drv = 3'd1;
    usr = 1'b0;
    ist = 1'b0;
  endtask : recover
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    final_report();
  end
  // ==========================================
  // main sequence
  initial
  begin
    {rstn, class_err, class_two, overrun, tune_out, homed} = 6'h0;
    {still, drv, usr, mode, ovr, hom, ist} = 9'h104;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    state(3'd0);
    bm_u.access(1'b0, `REG_CTRL, 32'h0, r);
    check("limit", r, 32'h0000ffff);
    repeat (4)
    begin
      bm_u.access(1'b0, 4'h7 + 4'({$random(seed)} % 9), 32'h0, r);
      check("unmapped", r, 32'h0);
    end
    cmd(32'h0080_0000);
    cmd(32'h0100_0000);
    wr(`REG_CTRL, 32'h2);
    drv = 3'd1;
    state(3'd1);
    cmd(32'h0180_0000);
    cmd(32'h0040_0000);
    wr(`REG_LIMIT, 32'h0000_0100);
    lim = 16'h0100;
    bm_u.access(1'b0, `REG_LIMIT, 32'h0, r);
    check("limit", r, 32'h0000_0100);
    cmd(32'h0001_ffff);
    cmd(32'h0001_8080);
    repeat (3)
    begin
      w = $random(seed);
      cmd({15'h0, 1'b1, w[15:0]});
    end
    still <= 1'b0;
    repeat (4) @(posedge clock);
    cmd(32'h0200_0000);
    cmd(32'h0008_0000);
    cmd(32'h0200_0000);
    cmd(32'h0002_0000);
    bm_u.access(1'b0, `REG_STATUS, 32'h0, r);
    check("motion finished", {31'h0, r[5]}, 32'h1);
    wr(`REG_CTRL, 32'h1);
    {drv, usr} = {3'd2, 1'b1};
    cmd(32'h0200_0000);
    recover();
    bm_u.access(1'b0, `REG_STATUS, 32'h0, r);
    check("user stop", {31'h0, r[3]}, 32'h0);
    state(3'd1);
    {class_err, class_two} <= 2'b10;
    repeat (4) @(posedge clock);
    class_err <= 1'b0;
    drv = 3'd2;
    state(3'd2);
    cmd(32'h0200_0000);
    recover();
    {class_err, class_two} <= 2'b11;
    repeat (4) @(posedge clock);
    {class_err, class_two} <= 2'b00;
    drv = 3'd3;
    state(3'd3);
    cmd(32'h0200_0000);
    recover();
    state(3'd1);
    cmd(32'h0210_0000);
    cmd(32'h0100_0000);
    overrun <= 1'b1;
    repeat (4) @(posedge clock);
    overrun <= 1'b0;
    {drv, ist, ovr} = {3'd2, 1'b1, 1'b1};
    state(3'd2);
    cmd(32'h0200_0000);
    recover();
    cmd(32'h0002_0000);
    cmd(32'h0020_0000);
    wr(`REG_MASK, 32'h4);
    repeat (2) @(posedge clock);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(`REG_MASK, 32'h0);
    repeat (2) @(posedge clock);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`REG_MASK, 32'h4);
    wr(`REG_IRQ, 32'hf);
    repeat (2) @(posedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    final_report();
  end
endmodule : drive_command_gatekeeper_tb_top

// ---- verification/gatekeeper_bus_master.sv ----
// Purpose: fieldbus master model speaking Avalon-MM
// Assumes: requests start right after a rising edge
// Notes: waits for the answer as long as it takes
`timescale 1ns/1ns
module gatekeeper_bus_master (
  input wire logic i_clock,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [3:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata
);
  initial
  begin
    o_address = 4'h0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
  end
  task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clock);
    o_address <= a;
    o_read <= !wr;
    o_write <= wr;
    o_writedata <= d;
    // request held until the edge that sees waitrequest low
    do @(posedge i_clock); while (i_waitrequest);
    r = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask : access
endmodule : gatekeeper_bus_master

// ---- verification/gatekeeper_properties.sv ----
// Purpose: port assertions of the drive command gatekeeper
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only the top-level ports
`timescale 1ns/1ns
`include "gatekeeper_params.svh"
module gatekeeper_checker
  import gatekeeper_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic o_waitrequest,
  input wire gatekeeper_pkg::reply_s o_reply,
  input wire logic o_reply_valid,
  input wire logic o_mode_run
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ==========================================
  // bus and reply timing
  sequence s_req_new; $rose(i_read || i_write); endsequence
  sequence s_cmd_new; $rose(i_write) && i_address == `REG_CMD; endsequence
  property p_answer; s_req_new |=> !o_waitrequest; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered after one wait state");
  property p_one_cycle; !o_waitrequest |=> o_waitrequest; endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("waitrequest low for more than one cycle");
  property p_idle_wait; !(i_read || i_write) |=> o_waitrequest; endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("answer without a request");
  property p_cmd_reply; s_cmd_new |=> o_reply_valid; endproperty
  a_cmd_reply: assert property (p_cmd_reply)
    else $error("command write without reply");
  property p_reply_cause; o_reply_valid |-> $past(i_write && i_address == `REG_CMD); endproperty
  a_reply_cause: assert property (p_reply_cause)
    else $error("reply without a command write");
  property p_reply_pulse; o_reply_valid |=> !o_reply_valid; endproperty
  a_reply_pulse: assert property (p_reply_pulse)
    else $error("reply valid longer than one cycle");
  property p_reply_hold; !o_reply_valid |-> $stable(o_reply); endproperty
  a_reply_hold: assert property (p_reply_hold)
    else $error("reply changed without reply valid");
  property p_err_flag; o_reply_valid |-> o_reply.err_valid == (o_reply.code != `ERR_NONE); endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error flag disagrees with code");
  property p_halt_ends; o_reply_valid && $past(i_writedata[17]) |-> !o_mode_run; endproperty
  a_halt_ends: assert property (p_halt_ends)
    else $error("hold-stop left the mode running");
endmodule : gatekeeper_checker
bind drive_command_gatekeeper gatekeeper_checker chk_u (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .o_waitrequest(o_waitrequest), .o_reply(o_reply), .o_reply_valid(o_reply_valid), .o_mode_run(o_mode_run));
